// ===== verilog/hall_sensor_diag_conversion_ctl.sv
// Diagnostic status register and conversion sequencer
// What this block does
// - Status bit mirrors read-back interrupt pin level
// - Readback bit resets high, then follows the pin
// - Sticky clock fault flag, write one clears
// - Sticky interrupt pin fault flag, W1C
// - Sticky trim memory CRC fault flag, W1C
// - Sticky supply undervoltage flag, W1C
// - Drift compensation code zero means none
// - Mode 10b converts continuously without trigger
// - Spin stage then ADC stage per sample
// - Spin stage overlaps previous ADC conversion
// - Temperature sampled at each new set
// - Mode 00b converts once per host trigger
// - Code 1011b sequences X, Z, X
// - XZX and YZY balance vertical axis noise
// - Limit check per axis, several together
// - Above, below, exit, enter band modes
// - Interrupt repeats every conversion while flagged
// - Band codes 010b-111b double in width
`timescale 1ns/1ps
`default_nettype none
module hall_sensor_diag_conversion_ctl (
   input  wire logic                          ref_clk,
   input  wire logic                          srst,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   input  wire logic [7:0]                    reg_addr,
   input  wire logic [7:0]                    reg_wdata,
   output logic      [7:0]                    reg_rdata,
   output logic                               reg_hit,
   input  wire hall_diag_pkg::fault_event_type fault_event,
   input  wire logic                          irq_pin_in,
   output logic                               irq_pin_out,
   output logic                               irq_pin_oe,
   input  wire logic [1:0]                    operating_mode,
   input  wire logic [3:0]                    axis_sequence_select,
   input  wire logic [1:0]                    magnet_drift_comp_select,
   input  wire logic                          host_trigger,
   input  wire logic                          pin_trigger_enable,
   input  wire logic [2:0]                    limit_axis_enable,
   input  wire logic [47:0]                   limit_threshold,
   input  wire logic [1:0]                    limit_direction_select,
   input  wire logic [2:0]                    limit_band_width_select,
   input  wire logic [15:0]                   adc_value,
   input  wire logic [15:0]                   temp_value,
   output logic                               spin_busy,
   output logic                               adc_busy,
   output hall_diag_pkg::sample_type          result,
   output logic      [15:0]                   temp_result,
   output logic                               drift_comp_active,
   output logic                               set_done
);
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_TEMP = 2'b01,
      SEQ_RUN  = 2'b10,
      SEQ_WAIT = 2'b11
   } seq_state_type;

   typedef struct packed {
      logic [3:0]                flags;
      seq_state_type             seq;
      logic [7:0]                tcnt;
      logic [1:0]                slot;
      logic                      spin_act;
      logic [7:0]                spin_cnt;
      hall_diag_pkg::axis_type   spin_axis;
      logic                      spin_last;
      logic                      adc_act;
      logic [7:0]                adc_cnt;
      hall_diag_pkg::axis_type   adc_axis;
      logic                      adc_last;
      hall_diag_pkg::sample_type res;
      logic [15:0]               temp;
      logic                      done;
      logic                      irq;
      logic                      trig_prev;
   } ctl_state_type;

   ctl_state_type st_q;
   ctl_state_type st_d;
   logic          pin_level;
   logic [2:0]    axis_hit;
   logic [3:0]    clr_mask;
   logic [3:0]    ev_mask;
   logic [1:0]    seq_len;
   hall_diag_pkg::axis_type slot_axis;
   logic          pin_trig;

   pin_sync u_pin_sync (
      .ref_clk   (ref_clk),
      .srst      (srst),
      .pin_in    (irq_pin_in),
      .level_out (pin_level)
   );

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : gen_limit
         limit_checker u_chk (
            .ref_clk      (ref_clk),
            .srst         (srst),
            .sample_valid (st_q.res.valid && limit_axis_enable[g] && st_q.res.axis == hall_diag_pkg::axis_type'(g)),
            .sample_value (st_q.res.value),
            .threshold    (limit_threshold[16*g +: 16]),
            .direction    (limit_direction_select),
            .band_select  (limit_band_width_select),
            .hit          (axis_hit[g])
         );
      end
   endgenerate

   // Axis order per enable code
   always_comb begin
      seq_len   = 2'd0;
      slot_axis = hall_diag_pkg::AXIS_X;
      case (axis_sequence_select)
         hall_diag_pkg::SEQ_XZX: begin
            seq_len   = 2'd2;
            slot_axis = (st_q.slot == 2'd1) ? hall_diag_pkg::AXIS_Z : hall_diag_pkg::AXIS_X;
         end
         hall_diag_pkg::SEQ_YZY: begin
            seq_len   = 2'd2;
            slot_axis = (st_q.slot == 2'd1) ? hall_diag_pkg::AXIS_Z : hall_diag_pkg::AXIS_Y;
         end
         default: begin
            // Any other code converts X, Y, Z in order; the bits enable nothing
            seq_len   = 2'd2;
            slot_axis = hall_diag_pkg::axis_type'(st_q.slot);
         end
      endcase
   end

   assign ev_mask  = {fault_event.clock_fault, fault_event.irq_pin_fault,
                      fault_event.trim_crc_fault, fault_event.undervoltage};
   assign clr_mask = (reg_wr && reg_addr == hall_diag_pkg::DIAG_STATUS_OFFSET)
                     ? (reg_wdata[3:0] & hall_diag_pkg::STICKY_MASK[3:0]) : 4'h0;
   assign pin_trig = pin_trigger_enable && !pin_level && !st_q.irq;

   always_comb begin
      st_d      = st_q;
      st_d.done = 1'b0;
      st_d.res.valid = 1'b0;
      st_d.trig_prev = pin_trig;
      // Set wins over a same-cycle clear
      st_d.flags = (st_q.flags & ~clr_mask) | ev_mask;
      // Spin stage countdown, hands to ADC when ADC is free
      if (st_q.spin_act && st_q.spin_cnt != 8'h00) begin
         st_d.spin_cnt = st_q.spin_cnt - 8'h01;
      end
      if (st_q.adc_act) begin
         if (st_q.adc_cnt != 8'h00) begin
            st_d.adc_cnt = st_q.adc_cnt - 8'h01;
         end else begin
            st_d.adc_act   = 1'b0;
            st_d.res.valid = 1'b1;
            st_d.res.axis  = st_q.adc_axis;
            st_d.res.value = adc_value;
            st_d.done      = st_q.adc_last;
         end
      end
      if (st_q.spin_act && st_q.spin_cnt == 8'h00 && (!st_q.adc_act || st_q.adc_cnt == 8'h00)) begin
         st_d.spin_act = 1'b0;
         st_d.adc_act  = 1'b1;
         st_d.adc_cnt  = hall_diag_pkg::ADC_CYCLES - 8'h01;
         st_d.adc_axis = st_q.spin_axis;
         st_d.adc_last = st_q.spin_last;
      end
      case (st_q.seq)
         SEQ_IDLE: begin
            if (operating_mode == hall_diag_pkg::MODE_CONTINUOUS
                || (operating_mode == hall_diag_pkg::MODE_TRIGGERED
                    && (host_trigger || (pin_trig && !st_q.trig_prev)))) begin
               st_d.seq  = SEQ_TEMP;
               st_d.tcnt = hall_diag_pkg::TEMP_CYCLES - 8'h01;
            end
         end
         SEQ_TEMP: begin
            if (st_q.tcnt != 8'h00) begin
               st_d.tcnt = st_q.tcnt - 8'h01;
            end else begin
               st_d.temp = temp_value;
               st_d.slot = 2'd0;
               st_d.seq  = SEQ_RUN;
            end
         end
         SEQ_RUN: begin
            if (!st_d.spin_act) begin
               st_d.spin_act  = 1'b1;
               st_d.spin_cnt  = hall_diag_pkg::SPIN_CYCLES - 8'h01;
               st_d.spin_axis = slot_axis;
               st_d.spin_last = (st_q.slot == seq_len);
               st_d.slot      = st_q.slot + 2'd1;
               if (st_q.slot == seq_len) begin
                  st_d.seq = SEQ_WAIT;
               end
            end
         end
         SEQ_WAIT: begin
            if (st_d.done) begin
               st_d.seq = SEQ_IDLE;
            end
         end
         default: st_d.seq = SEQ_IDLE;
      endcase
      // Fresh pulse on every conversion while in flagged region
      st_d.irq = |axis_hit;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_q         <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   always_comb begin
      reg_hit   = reg_rd && reg_addr == hall_diag_pkg::DIAG_STATUS_OFFSET;
      reg_rdata = 8'h00;
      if (reg_hit) begin
         reg_rdata = {3'b000, pin_level, st_q.flags};
      end
   end

   assign irq_pin_out       = 1'b0;
   assign irq_pin_oe        = st_q.irq;
   assign spin_busy         = st_q.spin_act;
   assign adc_busy          = st_q.adc_act;
   assign result            = st_q.res;
   assign temp_result       = st_q.temp;
   assign drift_comp_active = magnet_drift_comp_select != hall_diag_pkg::COMP_NONE;
   assign set_done          = st_q.done;
endmodule
`default_nettype wire

// ===== verilog/hall_diag_pkg.sv
// Shared constants and carrier types for the diagnostic and conversion block
package hall_diag_pkg;
   localparam logic [7:0] DIAG_STATUS_OFFSET = 8'h1c;
   localparam logic [7:0] DIAG_STATUS_RESET  = 8'h10;
   localparam int PIN_READBACK_BIT  = 4;
   localparam int CLOCK_FAULT_BIT   = 3;
   localparam int IRQ_FAULT_BIT     = 2;
   localparam int TRIM_CRC_BIT      = 1;
   localparam int UNDERVOLTAGE_BIT  = 0;
   localparam logic [4:0] STICKY_MASK = 5'h0f;

   localparam logic [1:0] MODE_TRIGGERED  = 2'h0;
   localparam logic [1:0] MODE_CONTINUOUS = 2'h2;
   localparam logic [1:0] COMP_NONE       = 2'h0;
   localparam logic [3:0] SEQ_XZX         = 4'hb;
   localparam logic [3:0] SEQ_YZY         = 4'hc;

   localparam logic [2:0] BAND_MIN_CODE = 3'h2;
   localparam logic [2:0] BAND_MAX_CODE = 3'h7;
   // Narrowest band width at lowest range, in microtesla
   localparam int BAND_BASE_UT = 156;

   localparam logic [1:0] DIR_ABOVE = 2'h0;
   localparam logic [1:0] DIR_BELOW = 2'h1;
   localparam logic [1:0] DIR_EXIT  = 2'h2;
   localparam logic [1:0] DIR_ENTER = 2'h3;

   // Stage durations in ns, cycle counts derived from 25 ns clock
   localparam int CLK_PERIOD_NS = 25;
   localparam int SPIN_TIME_NS  = 400;
   localparam int ADC_TIME_NS   = 400;
   localparam int TEMP_TIME_NS  = 400;
   localparam logic [7:0] SPIN_CYCLES = 8'((SPIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] ADC_CYCLES  = 8'((ADC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] TEMP_CYCLES = 8'((TEMP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef enum logic [1:0] {
      AXIS_X = 2'b00,
      AXIS_Y = 2'b01,
      AXIS_Z = 2'b10,
      AXIS_T = 2'b11
   } axis_type;

   typedef struct packed {
      logic       clock_fault;
      logic       irq_pin_fault;
      logic       trim_crc_fault;
      logic       undervoltage;
   } fault_event_type;

   typedef struct packed {
      logic        valid;
      axis_type    axis;
      logic [15:0] value;
   } sample_type;
endpackage

// ===== verilog/pin_sync.sv
// Three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
   input  wire logic ref_clk,
   input  wire logic srst,
   input  wire logic pin_in,
   output logic      level_out
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } sync_state_type;

   sync_state_type st_q;
   sync_state_type st_d;

   always_comb begin
      st_d     = st_q;
      st_d.s1  = pin_in;
      st_d.s2  = st_q.s1;
      st_d.s3  = st_q.s2;
      // Change counts once second and third stage agree
      if (st_q.s2 == st_q.s3) begin
         st_d.lvl = st_q.s3;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_q <= 4'hf;
      end else begin
         st_q <= st_d;
      end
   end

   assign level_out = st_q.lvl;
endmodule
`default_nettype wire

// ===== verilog/limit_checker.sv
// Per-axis threshold compare with direction and hysteresis band
`timescale 1ns/1ps
`default_nettype none
module limit_checker (
   input  wire logic        ref_clk,
   input  wire logic        srst,
   input  wire logic        sample_valid,
   input  wire logic [15:0] sample_value,
   input  wire logic [15:0] threshold,
   input  wire logic [1:0]  direction,
   input  wire logic [2:0]  band_select,
   output logic             hit
);
   typedef struct packed {
      logic hit;
   } chk_state_type;

   chk_state_type st_q;
   chk_state_type st_d;
   logic [15:0]   half_band;
   logic signed [16:0] upper;
   logic signed [16:0] lower;
   logic          above;
   logic          below;

   always_comb begin
      half_band = 16'h0000;
      if (band_select >= hall_diag_pkg::BAND_MIN_CODE) begin
         // Width doubles per code step
         half_band = 16'(16'h0001 << (band_select - hall_diag_pkg::BAND_MIN_CODE));
      end
      upper = $signed({threshold[15], threshold}) + $signed({1'b0, half_band});
      lower = $signed({threshold[15], threshold}) - $signed({1'b0, half_band});
      above = $signed({sample_value[15], sample_value}) > upper;
      below = $signed({sample_value[15], sample_value}) < lower;
      st_d  = st_q;
      st_d.hit = 1'b0;
      if (sample_valid) begin
         case (direction)
            hall_diag_pkg::DIR_ABOVE: st_d.hit = above;
            hall_diag_pkg::DIR_BELOW: st_d.hit = below;
            hall_diag_pkg::DIR_EXIT:  st_d.hit = above || below;
            hall_diag_pkg::DIR_ENTER: st_d.hit = !above && !below;
            default:                  st_d.hit = 1'b0;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_q <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   assign hit = st_q.hit;
endmodule
`default_nettype wire

// ===== tb/hall_diag_checker_assertions.sv
// Port-level assertions for the diagnostic and conversion block
`timescale 1ns/1ps
`default_nettype none
module hall_diag_checker (
   input wire logic                           ref_clk,
   input wire logic                           srst,
   input wire logic                           reg_wr,
   input wire logic                           reg_rd,
   input wire logic [7:0]                     reg_addr,
   input wire logic [7:0]                     reg_wdata,
   input wire logic [7:0]                     reg_rdata,
   input wire hall_diag_pkg::fault_event_type fault_event,
   input wire logic                           irq_pin_in,
   input wire logic [1:0]                     operating_mode,
   input wire logic [3:0]                     axis_sequence_select,
   input wire logic [1:0]                     magnet_drift_comp_select,
   input wire logic                           host_trigger,
   input wire logic                           spin_busy,
   input wire logic                           adc_busy,
   input wire hall_diag_pkg::sample_type      result,
   input wire logic                           drift_comp_active,
   input wire logic                           set_done
);
   wire logic       hit_ofs   = reg_addr == hall_diag_pkg::DIAG_STATUS_OFFSET;
   wire logic       stat_rd   = reg_rd && hit_ofs;
   wire logic [3:0] wmask     = (reg_wr && hit_ofs) ? reg_wdata[3:0] : 4'h0;
   wire logic [3:0] fev       = fault_event;
   wire logic       cont      = operating_mode == hall_diag_pkg::MODE_CONTINUOUS;
   wire logic       xzx       = axis_sequence_select == hall_diag_pkg::SEQ_XZX;
   wire logic       trig_idle = operating_mode == hall_diag_pkg::MODE_TRIGGERED && host_trigger && !spin_busy && !adc_busy;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);
   sequence ev_then_rd;
      (fev != 4'h0) ##1 (wmask == 4'h0) ##1 stat_rd;
   endsequence
   sequence clr_then_rd;
      (wmask != 4'h0) ##1 (fev == 4'h0) ##1 stat_rd;
   endsequence
   sequence pin_high;
      irq_pin_in [*8];
   endsequence
   sequence pin_low;
      (!irq_pin_in) [*8];
   endsequence
   AST_RESERVED: assert property (stat_rd |-> reg_rdata[7:5] == 3'h0)
      else $error("reserved status bits not zero");
   AST_SET: assert property (ev_then_rd |-> (reg_rdata[3:0] & $past(fev, 2)) == $past(fev, 2))
      else $error("fault event did not set its flag");
   AST_CLEAR: assert property (clr_then_rd |-> (reg_rdata[3:0] & $past(wmask & ~fev, 2)) == 4'h0)
      else $error("flag survived a clearing write");
   AST_RB_HIGH: assert property (pin_high ##0 stat_rd |-> reg_rdata[4])
      else $error("readback low while pin high");
   AST_RB_LOW: assert property (pin_low ##0 stat_rd |-> !reg_rdata[4])
      else $error("readback high while pin low");
   AST_COMP: assert property (magnet_drift_comp_select == hall_diag_pkg::COMP_NONE |-> !drift_comp_active)
      else $error("compensation active with none selected");
   AST_TRIG: assert property (trig_idle |-> ##[1:300] set_done)
      else $error("trigger gave no conversion set");
   AST_CONT: assert property (set_done && cont |-> ##[1:300] (set_done || !cont))
      else $error("continuous mode stalled");
   AST_SPIN_ADC: assert property ($rose(adc_busy) |-> $past(spin_busy))
      else $error("conversion stage without spin stage");
   AST_XZX: assert property (xzx && result.valid |-> result.axis != hall_diag_pkg::AXIS_Y)
      else $error("wrong axis in pseudo-simultaneous order");
endmodule
bind hall_sensor_diag_conversion_ctl hall_diag_checker chk_u (.ref_clk, .srst, .reg_wr, .reg_rd, .reg_addr,
   .reg_wdata, .reg_rdata, .fault_event, .irq_pin_in, .operating_mode, .axis_sequence_select,
   .magnet_drift_comp_select, .host_trigger, .spin_busy, .adc_busy, .result, .drift_comp_active, .set_done);
`default_nettype wire

// ===== tb/host_mcu_model.sv
// Host microcontroller side of the open-drain interrupt pin
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model (
   input  wire logic dev_oe,
   input  wire logic dev_out,
   input  wire logic host_pull,
   output logic      pin_level
);
   // Pull-up holds the pin high unless a party pulls it low
   assign pin_level = !((dev_oe && !dev_out) || host_pull);
endmodule
`default_nettype wire

// ===== tb/hall_sensor_diag_conversion_ctl_tb_top.sv
// Self-checking bench for the diagnostic and conversion block
`timescale 1ns/1ps
`default_nettype none
module hall_sensor_diag_conversion_ctl_tb_top;
   localparam logic [7:0] OFS = hall_diag_pkg::DIAG_STATUS_OFFSET;
   logic                           ref_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic                           host_trigger = 1'b0, pin_trigger_enable = 1'b0, host_pull = 1'b0;
   logic [7:0]                     reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic [1:0]                     operating_mode = 2'h0, magnet_drift_comp_select = 2'h0;
   logic [1:0]                     limit_direction_select = 2'h0;
   logic [3:0]                     axis_sequence_select = 4'h7, flags = 4'h0;
   logic [2:0]                     limit_axis_enable = 3'h0, limit_band_width_select = 3'h0;
   logic [47:0]                    limit_threshold = 48'h0000_0000_1000;
   logic [15:0]                    adc_value = 16'h0000, temp_value = 16'h0000, temp_result;
   hall_diag_pkg::fault_event_type fault_event = 4'h0;
   logic                           reg_hit, irq_pin_out, irq_pin_oe, spin_busy, adc_busy, drift_comp_active;
   logic                           set_done, pin_level, oe_prev;
   hall_diag_pkg::sample_type      result;
   hall_diag_pkg::axis_type        axq[$];
   int                             tq[$];
   int                             failures = 0, num_checks = 0, irq_cnt = 0, sets = 0, overlap = 0;
   logic [3:0]                     codes[3] = '{hall_diag_pkg::SEQ_XZX, hall_diag_pkg::SEQ_YZY, 4'h7};
   logic [5:0]                     order[3] = '{6'h08, 6'h19, 6'h06};
   // Limit corner cases: direction, band code, field value, expected interrupt count
   logic [1:0]                     ldir[7] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h2, 2'h3, 2'h3};
   logic [2:0]                     lband[7] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h6, 3'h6, 3'h5};
   logic [15:0]                    lval[7] = '{16'h2000, 16'h2000, 16'h2000, 16'h2000, 16'h1010, 16'h1010, 16'h1010};
   logic [15:0]                    lexp[7] = '{16'h0001, 16'h0001, 16'h0000, 16'h0003, 16'h0000, 16'h0001, 16'h0000};

   hall_sensor_diag_conversion_ctl dut_u (.ref_clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .reg_hit, .fault_event, .irq_pin_in(pin_level), .irq_pin_out, .irq_pin_oe, .operating_mode,
      .axis_sequence_select, .magnet_drift_comp_select, .host_trigger, .pin_trigger_enable, .limit_axis_enable,
      .limit_threshold, .limit_direction_select, .limit_band_width_select, .adc_value, .temp_value, .spin_busy,
      .adc_busy, .result, .temp_result, .drift_comp_active, .set_done);
   host_mcu_model host_u (.dev_oe(irq_pin_oe), .dev_out(irq_pin_out), .host_pull, .pin_level);

   initial forever #12.5 ref_clk = ~ref_clk;

   always @(posedge ref_clk) begin
      if (result.valid === 1'b1) chk(result.value, adc_value);
      if (result.valid === 1'b1 && result.axis !== hall_diag_pkg::AXIS_T) begin
         axq.push_back(result.axis);
         tq.push_back(int'($time));
      end
      if (irq_pin_oe === 1'b1 && oe_prev !== 1'b1) irq_cnt++;
      if (set_done === 1'b1) sets++;
      if (spin_busy === 1'b1 && adc_busy === 1'b1) overlap++;
      oe_prev = irq_pin_oe;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      chk(16'(reg_rdata), 16'(e));
      chk(16'(reg_hit), 16'(a == OFS));
      reg_rd <= 1'b0;
   endtask

   // Write with a fault event raised in the same cycle; expected flags follow
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] ev);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      fault_event <= ev;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      fault_event <= 4'h0;
      if (a == OFS) flags = flags & ~d[3:0];
      flags = flags | ev;
   endtask

   task automatic run_set(input logic use_pin);
      int n;
      axq.delete();
      tq.delete();
      irq_cnt = 0;
      @(posedge ref_clk);
      if (use_pin) host_pull <= 1'b1;
      else host_trigger <= 1'b1;
      cyc(use_pin ? 8 : 1);
      host_pull <= 1'b0;
      host_trigger <= 1'b0;
      n = 0;
      while (set_done !== 1'b1 && n < 400) begin
         @(posedge ref_clk);
         #1 n++;
      end
      chk(16'(n < 400), 16'h0001);
      cyc(4);
   endtask

   task automatic close_out();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      close_out();
   end

   initial begin
      logic [7:0] d;
      void'($urandom(32'ha8f3));
      cyc(6);
      srst <= 1'b0;
      cyc(8);
      chk(16'(drift_comp_active), 16'h0000);
      chk(16'(irq_pin_out), 16'h0000);
      rd(OFS, 8'h10);
      rd(8'h1b, 8'h00);
      repeat (24) begin
         d = 8'($urandom);
         wr({1'b1, 7'($urandom)}, d, 4'($urandom));
         rd(OFS, {4'h1, flags});
         wr(OFS, d, 4'h0);
         rd(OFS, {4'h1, flags});
      end
      // Event in the clearing cycle must win
      wr(8'h80, 8'h00, 4'hf);
      wr(OFS, 8'hff, 4'h4);
      rd(OFS, 8'h14);
      wr(OFS, 8'hff, 4'h0);
      host_pull <= 1'b1;
      cyc(10);
      rd(OFS, 8'h00);
      host_pull <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         axis_sequence_select <= codes[i];
         pin_trigger_enable <= (i == 1);
         adc_value <= 16'($urandom);
         run_set(i == 1);
         chk(16'(axq.size()), 16'h0003);
         chk(16'({axq[0], axq[1], axq[2]}), 16'(order[i]));
         if (i < 2) chk(16'(tq[1] - tq[0]), 16'(tq[2] - tq[1]));
      end
      chk(16'(overlap > 0), 16'h0001);
      limit_threshold <= {3{16'h1000}};
      for (int k = 0; k < 7; k++) begin
         limit_axis_enable <= (k == 3) ? 3'h7 : 3'h1;
         limit_direction_select <= ldir[k];
         limit_band_width_select <= lband[k];
         adc_value <= lval[k];
         run_set(1'b0);
         chk(16'(irq_cnt), lexp[k]);
      end
      limit_axis_enable <= 3'h0;
      temp_value <= 16'($urandom);
      magnet_drift_comp_select <= 2'($urandom);
      operating_mode <= hall_diag_pkg::MODE_CONTINUOUS;
      sets = 0;
      cyc(400);
      chk(16'(sets > 2), 16'h0001);
      chk(temp_result, temp_value);
      chk(16'(drift_comp_active), 16'(magnet_drift_comp_select != hall_diag_pkg::COMP_NONE));
      operating_mode <= hall_diag_pkg::MODE_TRIGGERED;
      cyc(200);
      close_out();
   end
endmodule
`default_nettype wire
